// [shared/osc_switch_pkg.sv]
`default_nettype none
package osc_switch_pkg;

  // ***************************************************************
  // Bus and register map
  // ***************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_LO    = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_HI    = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG     = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 4'h4;

  // ***************************************************************
  // Unlock keys
  // ***************************************************************
  localparam logic [7:0] KEY_HI_FIRST  = 8'h78;
  localparam logic [7:0] KEY_HI_SECOND = 8'h9A;
  localparam logic [7:0] KEY_LO_FIRST  = 8'h46;
  localparam logic [7:0] KEY_LO_SECOND = 8'h57;

  // ***************************************************************
  // Field layout of oscillator_control and own registers
  // ***************************************************************
  localparam int SRC_W    = 3;
  localparam int NUM_SRC  = 8;
  localparam int CUR_LSB  = 12;
  localparam int NXT_LSB  = 8;
  localparam int LOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int GO_BIT   = 0;
  localparam int CFG_W        = 3;
  localparam int CFG_WATCHDOG_BIT  = 0;
  localparam int CFG_FAILSAFE_BIT  = 1;
  localparam int CFG_SECONDARY_BIT = 2;
  localparam int IRQ_W        = 3;
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_ABORT_BIT = 1;
  localparam int IRQ_FAIL_BIT  = 2;

  // ***************************************************************
  // Source encodings and timing
  // ***************************************************************
  localparam logic [SRC_W-1:0]   RESET_SOURCE    = 3'h0;
  localparam logic [SRC_W-1:0]   SOURCE_LOW_POWER_RC = 3'h5;
  localparam logic [SRC_W-1:0]   SOURCE_SECONDARY    = 3'h4;
  localparam logic [NUM_SRC-1:0] CRYSTAL_SOURCES = 8'h06;
  localparam logic [NUM_SRC-1:0] PLL_SOURCES     = 8'h0A;
  localparam int                 SETTLE_W        = 4;
  localparam logic [SETTLE_W-1:0] SETTLE_EDGES   = 4'hA;

  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_CHECK, SEQ_START, SEQ_WAIT_READY, SEQ_SETTLE, SEQ_CHANGE
  } seq_state_type;

  function automatic logic [NUM_SRC-1:0] source_onehot(input logic [SRC_W-1:0] src);
    return 8'h01 << src;
  endfunction

endpackage
`default_nettype wire

// [logic/unlock_guard.sv]
`timescale 1ns/1ps
`default_nettype none
module unlock_guard
  import osc_switch_pkg::*;
#(
  parameter logic [7:0] FIRST_KEY  = 8'h00,
  parameter logic [7:0] SECOND_KEY = 8'h00
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       writeStrobe,
  input  wire logic       byteHit,
  input  wire logic [7:0] writeByte,
  output logic            writeAllowed
);

  typedef enum logic [1:0] {GUARD_LOCKED, GUARD_HALF, GUARD_OPEN} guard_state_type;

  guard_state_type state_ff;
  guard_state_type nxt_state;

  // Any bus write, to any address, counts as the next step; reads do not.
  always_comb begin
    nxt_state = state_ff;
    if (writeStrobe) begin
      unique case (state_ff)
        GUARD_LOCKED: begin
          if (byteHit && writeByte == FIRST_KEY) nxt_state = GUARD_HALF;
        end
        GUARD_HALF: begin
          nxt_state = (byteHit && writeByte == SECOND_KEY) ? GUARD_OPEN : GUARD_LOCKED;
        end
        GUARD_OPEN: begin
          nxt_state = GUARD_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) state_ff <= GUARD_LOCKED;
    else       state_ff <= nxt_state;
  end

  assign writeAllowed = (state_ff == GUARD_OPEN) && writeStrobe && byteHit;

endmodule // unlock_guard
`default_nettype wire

// [logic/settle_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module settle_counter
  import osc_switch_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic start,
  input  wire logic sampleLevel,
  output logic      done
);

  logic [SETTLE_W-1:0] count_ff;
  logic [SETTLE_W-1:0] nxt_count;
  logic                prev_ff;
  logic                nxt_prev;

  always_comb begin
    nxt_prev  = sampleLevel;
    nxt_count = count_ff;
    if (start) begin
      nxt_count = '0;
    end else if (sampleLevel && !prev_ff && count_ff != SETTLE_EDGES) begin
      nxt_count = count_ff + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count_ff <= '0;
      prev_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      prev_ff  <= nxt_prev;
    end
  end

  assign done = (count_ff == SETTLE_EDGES);

endmodule // settle_counter
`default_nettype wire

// [logic/oscillator_switch_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module oscillator_switch_sequencer
  import osc_switch_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic [ADDR_W-1:0]  address,
  input  wire logic [DATA_W-1:0]  writeData,
  input  wire logic               writeStrobe,
  input  wire logic               readStrobe,
  output logic      [DATA_W-1:0]  readData,
  output logic                    interruptRequest,
  input  wire logic [NUM_SRC-1:0] sourceClock,
  input  wire logic [NUM_SRC-1:0] sourceReady,
  input  wire logic [NUM_SRC-1:0] startupTimerDone,
  input  wire logic               pllLocked,
  input  wire logic               clockFailDetect,
  output logic      [NUM_SRC-1:0] sourceEnable,
  output logic      [SRC_W-1:0]   systemClockSelect,
  output logic                    switchBusy
);

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  localparam int SYNC_W = 4 * NUM_SRC - NUM_SRC + 2;

  logic [SYNC_W-1:0] syncMeta_ff;
  logic [SYNC_W-1:0] syncSafe_ff;
  logic [SYNC_W-1:0] nxt_syncMeta;
  logic [SYNC_W-1:0] nxt_syncSafe;
  logic [NUM_SRC-1:0] clockS;
  logic [NUM_SRC-1:0] readyS;
  logic [NUM_SRC-1:0] timerDoneS;
  logic               pllLockS;
  logic               clockFailS;

  always_comb begin
    nxt_syncMeta = {clockFailDetect, pllLocked, startupTimerDone, sourceReady, sourceClock};
    nxt_syncSafe = syncMeta_ff;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      syncMeta_ff <= '0;
      syncSafe_ff <= '0;
    end else begin
      syncMeta_ff <= nxt_syncMeta;
      syncSafe_ff <= nxt_syncSafe;
    end
  end

  assign {clockFailS, pllLockS, timerDoneS, readyS, clockS} = syncSafe_ff;

  // ***************************************************************
  // Unlock guards
  // ***************************************************************
  logic hiAllowed;
  logic loAllowed;

  unlock_guard #(.FIRST_KEY(KEY_HI_FIRST), .SECOND_KEY(KEY_HI_SECOND)) hiGuard (
    .clock        (clock),
    .reset        (reset),
    .writeStrobe  (writeStrobe),
    .byteHit      (address == ADDR_CTRL_HI),
    .writeByte    (writeData[7:0]),
    .writeAllowed (hiAllowed)
  );

  unlock_guard #(.FIRST_KEY(KEY_LO_FIRST), .SECOND_KEY(KEY_LO_SECOND)) loGuard (
    .clock        (clock),
    .reset        (reset),
    .writeStrobe  (writeStrobe),
    .byteHit      (address == ADDR_CTRL_LO),
    .writeByte    (writeData[7:0]),
    .writeAllowed (loAllowed)
  );

  // ***************************************************************
  // Settle counter on the new source clock
  // ***************************************************************
  // The new clock is sampled at the system rate, so it must run below
  // half of that rate for every edge to be counted.
  seq_state_type    state_ff;
  seq_state_type    nxt_state;
  logic [SRC_W-1:0] curSource_ff;
  logic [SRC_W-1:0] nextSource_ff;
  logic             settleDone;

  settle_counter settle (
    .clock       (clock),
    .reset       (reset),
    .start       (state_ff == SEQ_WAIT_READY),
    .sampleLevel (clockS[nextSource_ff]),
    .done        (settleDone)
  );

  // ***************************************************************
  // Sequencer and oscillator_control register
  // ***************************************************************
  logic [SRC_W-1:0]   nxt_curSource;
  logic [SRC_W-1:0]   nxt_nextSource;
  logic               go_ff;
  logic               nxt_go;
  logic               lock_ff;
  logic               nxt_lock;
  logic               fail_ff;
  logic               nxt_fail;
  logic [NUM_SRC-1:0] sourceOn_ff;
  logic [NUM_SRC-1:0] nxt_sourceOn;
  logic [NUM_SRC-1:0] keepOn;
  logic [CFG_W-1:0]   config_ff;
  logic               newReady;
  logic               evDone;
  logic               evAbort;

  // Sources that must stay running across a changeover.
  always_comb begin
    keepOn = '0;
    if (config_ff[CFG_WATCHDOG_BIT] || config_ff[CFG_FAILSAFE_BIT]) begin
      keepOn[SOURCE_LOW_POWER_RC] = 1'b1;
    end
    if (config_ff[CFG_SECONDARY_BIT]) keepOn[SOURCE_SECONDARY] = 1'b1;
  end

  assign newReady = readyS[nextSource_ff]
                 && (!CRYSTAL_SOURCES[nextSource_ff] || timerDoneS[nextSource_ff])
                 && (!PLL_SOURCES[nextSource_ff] || pllLockS);

  always_comb begin
    nxt_state      = state_ff;
    nxt_curSource  = curSource_ff;
    nxt_nextSource = nextSource_ff;
    nxt_go         = go_ff;
    nxt_lock       = lock_ff;
    nxt_fail       = fail_ff || clockFailS;
    nxt_sourceOn   = sourceOn_ff;
    evDone         = 1'b0;
    evAbort        = 1'b0;
    // The selection is frozen while a switch runs so the compare stays valid.
    if (hiAllowed && state_ff == SEQ_IDLE && !go_ff) begin
      nxt_nextSource = writeData[NXT_LSB-8 +: SRC_W];
    end
    if (loAllowed && state_ff == SEQ_IDLE && writeData[GO_BIT]) begin
      nxt_go = 1'b1;
    end
    unique case (state_ff)
      SEQ_IDLE: begin
        if (go_ff) nxt_state = SEQ_CHECK;
      end
      SEQ_CHECK: begin
        if (nextSource_ff == curSource_ff) begin
          nxt_go    = 1'b0;
          evAbort   = 1'b1;
          nxt_state = SEQ_IDLE;
        end else begin
          nxt_lock  = 1'b0;
          nxt_fail  = clockFailS;
          nxt_state = SEQ_START;
        end
      end
      SEQ_START: begin
        nxt_sourceOn = sourceOn_ff | source_onehot(nextSource_ff);
        nxt_state    = SEQ_WAIT_READY;
      end
      SEQ_WAIT_READY: begin
        if (PLL_SOURCES[nextSource_ff] && pllLockS) nxt_lock = 1'b1;
        if (newReady) nxt_state = SEQ_SETTLE;
      end
      SEQ_SETTLE: begin
        if (settleDone) nxt_state = SEQ_CHANGE;
      end
      SEQ_CHANGE: begin
        nxt_curSource = nextSource_ff;
        nxt_go        = 1'b0;
        nxt_sourceOn  = source_onehot(nextSource_ff) | keepOn;
        evDone        = 1'b1;
        nxt_state     = SEQ_IDLE;
      end
      default: begin
        nxt_state = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff      <= SEQ_IDLE;
      curSource_ff  <= RESET_SOURCE;
      nextSource_ff <= RESET_SOURCE;
      go_ff         <= 1'b0;
      lock_ff       <= 1'b0;
      fail_ff       <= 1'b0;
      sourceOn_ff   <= source_onehot(RESET_SOURCE);
    end else begin
      state_ff      <= nxt_state;
      curSource_ff  <= nxt_curSource;
      nextSource_ff <= nxt_nextSource;
      go_ff         <= nxt_go;
      lock_ff       <= nxt_lock;
      fail_ff       <= nxt_fail;
      sourceOn_ff   <= nxt_sourceOn;
    end
  end

  // The core keeps running on curSource_ff until the changeover state.
  assign systemClockSelect = curSource_ff;
  assign sourceEnable      = sourceOn_ff;
  assign switchBusy        = go_ff;

  // ***************************************************************
  // Configuration, interrupts and read port
  // ***************************************************************
  logic [CFG_W-1:0]  nxt_config;
  logic [IRQ_W-1:0]  status_ff;
  logic [IRQ_W-1:0]  nxt_status;
  logic [IRQ_W-1:0]  mask_ff;
  logic [IRQ_W-1:0]  nxt_mask;
  logic [IRQ_W-1:0]  events;
  logic [DATA_W-1:0] readData_ff;
  logic [DATA_W-1:0] nxt_readData;
  logic [DATA_W-1:0] ctrlWord;

  always_comb begin
    ctrlWord = '0;
    ctrlWord[CUR_LSB +: SRC_W] = curSource_ff;
    ctrlWord[NXT_LSB +: SRC_W] = nextSource_ff;
    ctrlWord[LOCK_BIT]         = lock_ff;
    ctrlWord[FAIL_BIT]         = fail_ff;
    ctrlWord[GO_BIT]           = go_ff;
    events = '0;
    events[IRQ_DONE_BIT]  = evDone;
    events[IRQ_ABORT_BIT] = evAbort;
    events[IRQ_FAIL_BIT]  = clockFailS && !fail_ff;
    nxt_config = config_ff;
    nxt_mask   = mask_ff;
    if (writeStrobe && address == ADDR_CONFIG)   nxt_config = writeData[CFG_W-1:0];
    if (writeStrobe && address == ADDR_IRQ_MASK) nxt_mask   = writeData[IRQ_W-1:0];
    // A new event in the clearing read's cycle survives the clear.
    nxt_status = status_ff | events;
    if (readStrobe && address == ADDR_IRQ_STATUS) nxt_status = events;
    nxt_readData = '0;
    if (readStrobe) begin
      unique case (address)
        ADDR_CTRL_LO, ADDR_CTRL_HI: nxt_readData = ctrlWord;
        ADDR_CONFIG:                nxt_readData[CFG_W-1:0] = config_ff;
        ADDR_IRQ_STATUS:            nxt_readData[IRQ_W-1:0] = status_ff;
        ADDR_IRQ_MASK:              nxt_readData[IRQ_W-1:0] = mask_ff;
        default:                    nxt_readData = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      config_ff   <= '0;
      status_ff   <= '0;
      mask_ff     <= '0;
      readData_ff <= '0;
    end else begin
      config_ff   <= nxt_config;
      status_ff   <= nxt_status;
      mask_ff     <= nxt_mask;
      readData_ff <= nxt_readData;
    end
  end

  assign readData         = readData_ff;
  assign interruptRequest = |(status_ff & mask_ff);

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence seqWaitToSettle;
    state_ff == SEQ_WAIT_READY && newReady ##1 state_ff == SEQ_SETTLE;
  endsequence

  sequence seqChangeover;
    state_ff == SEQ_SETTLE && settleDone ##1 state_ff == SEQ_CHANGE;
  endsequence

  AST_HI_KEYED: assert property ($changed(nextSource_ff) |-> $past(hiAllowed))
    else $error("next source changed without high byte unlock");
  AST_LO_KEYED: assert property ($rose(go_ff) |-> $past(loAllowed))
    else $error("switch-go set without low byte unlock");
  AST_CUR_READ: assert property (readStrobe && address == ADDR_CTRL_LO
    |=> readData[CUR_LSB +: SRC_W] == $past(curSource_ff))
    else $error("current source not readable at its field");
  AST_REDUNDANT: assert property (state_ff == SEQ_CHECK && nextSource_ff == curSource_ff
    |=> !go_ff && state_ff == SEQ_IDLE && status_ff[IRQ_ABORT_BIT])
    else $error("redundant switch not aborted");
  AST_FLAGS_CLEAR: assert property (state_ff == SEQ_CHECK && nextSource_ff != curSource_ff
    && !clockFailS |=> !lock_ff && !fail_ff)
    else $error("lock or fail flag not cleared on valid switch");
  AST_NEW_ON: assert property (state_ff == SEQ_START |=> sourceEnable[nextSource_ff])
    else $error("new source not enabled");
  AST_PLL_WAIT: assert property (state_ff == SEQ_WAIT_READY && PLL_SOURCES[nextSource_ff]
    && !pllLockS |=> state_ff == SEQ_WAIT_READY)
    else $error("left wait before pll lock");
  AST_SETTLE: assert property (seqWaitToSettle |-> !settleDone [*2])
    else $error("settle count finished too early");
  AST_SUCCESS: assert property (seqChangeover |=> !go_ff
    && curSource_ff == $past(nextSource_ff) && sourceEnable == $past(source_onehot(nextSource_ff) | keepOn))
    else $error("changeover did not update state");
  AST_OLD_CLOCK: assert property ($changed(systemClockSelect) |-> $past(state_ff == SEQ_CHANGE))
    else $error("system clock changed outside changeover");

endmodule // oscillator_switch_sequencer
`default_nettype wire

// [testbench/osc_source_model.sv]
`timescale 1ns/1ps
`default_nettype none
module osc_source_model
  import osc_switch_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic [NUM_SRC-1:0] sourceEnable,
  input  wire logic               slowStart,
  input  wire logic               holdLock,
  output logic      [NUM_SRC-1:0] sourceClock,
  output logic      [NUM_SRC-1:0] sourceReady,
  output logic      [NUM_SRC-1:0] startupTimerDone,
  output logic                    pllLocked
);
  logic [7:0] age_ff [NUM_SRC];
  logic [1:0] phase_ff;
  logic       level_ff;
  logic [7:0] readyAt;

  // ***************************************************************
  // Source behaviour
  // ***************************************************************
  // Each source clock runs at one sixth of the system clock and stands low while disabled.
  always_ff @(posedge clock) begin
    phase_ff <= (reset || phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
    level_ff <= reset ? 1'b0 : (phase_ff == 2'h2) ? ~level_ff : level_ff;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (reset || !sourceEnable[i]) begin
        age_ff[i] <= 8'h00;
      end else if (age_ff[i] != 8'hFF) begin
        age_ff[i] <= age_ff[i] + 8'h01;
      end
    end
  end

  always_comb begin
    readyAt = slowStart ? 8'h60 : 8'h08;
    pllLocked = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      sourceClock[i] = sourceEnable[i] && age_ff[i] >= 8'h04 && level_ff;
      sourceReady[i] = age_ff[i] >= readyAt;
      startupTimerDone[i] = age_ff[i] >= readyAt + (CRYSTAL_SOURCES[i] ? 8'h10 : 8'h00);
      if (PLL_SOURCES[i] && age_ff[i] >= readyAt + 8'h20 && !holdLock) begin
        pllLocked = 1'b1;
      end
    end
  end
endmodule // osc_source_model
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end
module tb_top
  import osc_switch_pkg::*;
;
  logic               clock;
  logic               reset;
  logic [ADDR_W-1:0]  address;
  logic [DATA_W-1:0]  writeData;
  logic               writeStrobe;
  logic               readStrobe;
  logic [DATA_W-1:0]  readData;
  logic               interruptRequest;
  logic [NUM_SRC-1:0] sourceClock;
  logic [NUM_SRC-1:0] sourceReady;
  logic [NUM_SRC-1:0] startupTimerDone;
  logic               pllLocked;
  logic               clockFailDetect;
  logic [NUM_SRC-1:0] sourceEnable;
  logic [SRC_W-1:0]   systemClockSelect;
  logic               switchBusy;
  logic               slowStart;
  logic               holdLock;
  logic               rdPend_ff;
  logic [DATA_W-1:0]  expQ [$];
  logic [DATA_W-1:0]  expWord;
  int                 fail_count = 0;
  int                 n_tests = 0;
  int                 seed;
  int                 rdyCnt;

  oscillator_switch_sequencer DUT (.clock(clock), .reset(reset), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .interruptRequest(interruptRequest), .sourceClock(sourceClock),
    .sourceReady(sourceReady), .startupTimerDone(startupTimerDone), .pllLocked(pllLocked),
    .clockFailDetect(clockFailDetect), .sourceEnable(sourceEnable),
    .systemClockSelect(systemClockSelect), .switchBusy(switchBusy));

  osc_source_model sources (.clock(clock), .reset(reset), .sourceEnable(sourceEnable),
    .slowStart(slowStart), .holdLock(holdLock), .sourceClock(sourceClock),
    .sourceReady(sourceReady), .startupTimerDone(startupTimerDone), .pllLocked(pllLocked));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ***************************************************************
  // Bus tasks
  // ***************************************************************
  // Each of wr, rd and idle drives both strobes (wr and rd lower the other one) so back-to-back cycles never leave a stale strobe high.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    readStrobe <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    expQ.push_back(e);
    address <= a;
    writeStrobe <= 1'b0;
    readStrobe <= 1'b1;
    @(posedge clock);
  endtask

  task automatic idle();
    writeStrobe <= 1'b0;
    readStrobe <= 1'b0;
    @(posedge clock);
  endtask

  task automatic setNext(input logic [SRC_W-1:0] src);
    wr(ADDR_CTRL_HI, {8'h00, KEY_HI_FIRST});
    wr(ADDR_CTRL_HI, {8'h00, KEY_HI_SECOND});
    wr(ADDR_CTRL_HI, {13'h0000, src});
  endtask

  task automatic go();
    wr(ADDR_CTRL_LO, {8'h00, KEY_LO_FIRST});
    wr(ADDR_CTRL_LO, {8'h00, KEY_LO_SECOND});
    wr(ADDR_CTRL_LO, 16'h0001);
    idle();
    #1;
    `CHK(switchBusy, 1'b1)
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic waitSwitch(input logic [SRC_W-1:0] old, input logic [SRC_W-1:0] tgt);
    int i;
    rdyCnt = 0;
    for (i = 0; i < 3000 && switchBusy !== 1'b0; i++) begin
      `CHK(systemClockSelect, old)
      if (sourceReady[tgt] && startupTimerDone[tgt]) rdyCnt++;
      @(posedge clock);
      #1;
    end
    if (i == 3000) begin
      fail_count++;
      $display("[FAIL] %0t switch never finished", $time);
      test_done();
    end
    `CHK(systemClockSelect, tgt)
  endtask

  // Read data stands only in the cycle after the strobe and reads zero otherwise.
  always @(posedge clock) begin
    if (reset) begin
      rdPend_ff <= 1'b0;
    end else begin
      expWord = rdPend_ff ? expQ.pop_front() : 16'h0000;
      `CHK(readData, expWord)
      rdPend_ff <= readStrobe;
    end
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    seed = 15;
    {address, writeData, writeStrobe, readStrobe} = '0;
    {clockFailDetect, slowStart, holdLock} = 3'h0;
    reset = 1'b1;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    `CHK(sourceEnable, 8'h01)
    `CHK(systemClockSelect, 3'h0)
    `CHK(interruptRequest, 1'b0)
    @(posedge clock);
    rd(ADDR_CTRL_LO, 16'h0000);
    rd(ADDR_CONFIG, 16'h0000);
    rd(ADDR_IRQ_MASK, 16'h0000);
    wr(4'hF, 16'($random(seed)));
    rd(4'hF, 16'h0000);
    // Broken unlocks: wrong key, foreign write after the first or the second key.
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CTRL_HI, {8'h00, KEY_HI_FIRST});
      if (k == 1) wr(ADDR_CONFIG, 16'h0000);
      wr(ADDR_CTRL_HI, {8'h00, (k == 0) ? 8'h9B : KEY_HI_SECOND});
      if (k == 2) wr(ADDR_CONFIG, 16'h0000);
      wr(ADDR_CTRL_HI, {13'h0000, 3'($random(seed)) | 3'h1});
      rd(ADDR_CTRL_HI, 16'h0000);
    end
    wr(ADDR_CTRL_HI, {8'h00, KEY_HI_FIRST});
    rd(ADDR_CTRL_LO, 16'h0000);
    wr(ADDR_CTRL_HI, {8'h00, KEY_HI_SECOND});
    wr(ADDR_CTRL_HI, 16'h0006);
    rd(ADDR_CTRL_HI, 16'h0600);
    wr(ADDR_CTRL_LO, {8'h00, KEY_LO_FIRST});
    wr(ADDR_IRQ_MASK, 16'h0000);
    wr(ADDR_CTRL_LO, {8'h00, KEY_LO_SECOND});
    wr(ADDR_CTRL_LO, 16'h0001);
    idle();
    #1;
    `CHK(switchBusy, 1'b0)
    // Redundant request aborts and raises its status bit.
    @(posedge clock);
    wr(ADDR_IRQ_MASK, 16'h0007);
    setNext(3'h0);
    go();
    waitSwitch(3'h0, 3'h0);
    `CHK(interruptRequest, 1'b1)
    @(posedge clock);
    rd(ADDR_IRQ_STATUS, 16'h0002);
    idle();
    idle();
    #1;
    `CHK(interruptRequest, 1'b0)
    // Crystal source with slow start-up.
    @(posedge clock);
    slowStart <= 1'b1;
    setNext(3'h2);
    go();
    repeat (5) @(posedge clock);
    #1;
    `CHK(sourceEnable, 8'h05)
    waitSwitch(3'h0, 3'h2);
    `CHK(rdyCnt >= 55, 1'b1)
    `CHK(sourceEnable, 8'h04)
    @(posedge clock);
    rd(ADDR_CTRL_LO, 16'h2200);
    rd(ADDR_IRQ_STATUS, 16'h0001);
    // PLL source whose lock is withheld, then granted.
    slowStart <= 1'b0;
    holdLock <= 1'b1;
    wr(ADDR_CONFIG, 16'h0005);
    rd(ADDR_CONFIG, 16'h0005);
    setNext(3'h3);
    go();
    repeat (200) @(posedge clock);
    rd(ADDR_CTRL_LO, 16'h2301);
    holdLock <= 1'b1;
    idle();
    #1;
    `CHK(switchBusy, 1'b1)
    @(posedge clock);
    holdLock <= 1'b0;
    @(posedge clock);
    #1;
    waitSwitch(3'h2, 3'h3);
    `CHK(sourceEnable, 8'h38)
    @(posedge clock);
    rd(ADDR_CTRL_LO, 16'h3320);
    // Clock failure while masked, then unmasked; a valid switch clears both flags.
    wr(ADDR_IRQ_MASK, 16'h0000);
    clockFailDetect <= 1'b1;
    idle();
    repeat (5) @(posedge clock);
    clockFailDetect <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    `CHK(interruptRequest, 1'b0)
    @(posedge clock);
    wr(ADDR_IRQ_MASK, 16'h0004);
    idle();
    idle();
    #1;
    `CHK(interruptRequest, 1'b1)
    @(posedge clock);
    rd(ADDR_IRQ_STATUS, 16'h0005);
    rd(ADDR_CTRL_LO, 16'h3328);
    setNext(3'h2);
    go();
    waitSwitch(3'h3, 3'h2);
    `CHK(sourceEnable, 8'h34)
    @(posedge clock);
    rd(ADDR_CTRL_LO, 16'h2200);
    idle();
    idle();
    `CHK(expQ.size(), 0)
    test_done();
  end
endmodule // tb_top
`default_nettype wire
